/* tb.sv */
/* self-checking bench for the escape command decoder.
   assumes the host model drives the register bus. */
`timescale 1ns/1ns
`include "tecd_map.vh"
module tb;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        menu_permission_config_switch = 1'b1;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, menu_show, clear_req;
    logic        partial_redraw, char_half, attr_inverse, attr_flash;
    logic        attr_flash_inverse;
    logic [2:0]  enlarge_sel;
    logic [1:0]  r;
    int          error_cnt = 0;
    int          comparisons = 0;

    tecd_decoder dut_u (.*);
    tecd_host_model host_u (.*);

    always #25 mclk = ~mclk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        host_u.axi_wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic [31:0] v;
        host_u.axi_rd(a, v, r);
        chk(v, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic look(input logic [7:0] e);
        chk({24'h0, menu_show, char_half, enlarge_sel, attr_inverse,
             attr_flash, attr_flash_inverse}, {24'h0, e});
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] p,
                       input logic n, input logic [7:0] e);
        wr(`TECD_REG_RXDATA, {24'h0, `TECD_ESC}, 2'h0);
        wr(`TECD_REG_RXDATA, {24'h0, c}, 2'h0);
        if (n) wr(`TECD_REG_RXDATA, {24'h0, p}, 2'h0);
        look(e);
    endtask
    task automatic rst(input logic sw);
        @(posedge mclk);
        menu_permission_config_switch <= sw;
        nrst <= 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #3000000;
        error_cnt++;
        give_verdict;
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        rst(1'b1);
        rd(`TECD_REG_STATUS, 32'h1, 2'h0);
        look(8'h80);
        $display("test reset done");
        cmd(8'h57, 8'h31, 1, 8'h00);
        cmd(8'h57, 8'h30, 1, 8'h80);
        cmd(8'h57, 8'h32, 1, 8'h80);
        cmd(8'h29, 8'h31, 1, 8'hc0);
        cmd(8'h29, 8'h36, 1, 8'hc0);
        for (logic [7:0] k = 0; k < 6; k++)
            cmd(8'h2a, 8'h30 + k, 1, 8'hc0 | (k << 3));
        cmd(8'h2a, 8'h36, 1, 8'he8);
        cmd(8'h29, 8'h30, 1, 8'ha8);
        $display("test menu size enlarge done");
        cmd(8'h22, 8'h0, 0, 8'hac);
        cmd(8'h24, 8'h0, 0, 8'haf);
        cmd(8'h23, 8'h0, 0, 8'haa);
        cmd(8'h22, 8'h0, 0, 8'haf);
        cmd(8'h25, 8'h0, 0, 8'hac);
        cmd(8'h24, 8'h0, 0, 8'haf);
        cmd(8'h21, 8'h0, 0, 8'ha8);
        wr(`TECD_REG_RXDATA, {24'h0, `TECD_ESC}, 2'h0);
        cmd(8'h22, 8'h0, 0, 8'hac);
        $display("test attributes done");
        cmd(8'h26, 8'h0, 0, 8'hac);
        rd(`TECD_REG_STATUS, 32'h155, 2'h0);
        rd(`TECD_REG_SCREEN, 32'h1, 2'h0);
        wr(`TECD_REG_CTRL, 32'h2, 2'h0);
        rd(`TECD_REG_STATUS, 32'h55, 2'h0);
        wr(`TECD_REG_CTRL, 32'h1, 2'h0);
        look(8'h80);
        rd(`TECD_REG_SCREEN, 32'h0, 2'h0);
        rd(4'h2, 32'h0, 2'h2);
        wr(4'h6, 32'h22, 2'h2);
        look(8'h80);
        $display("test clear screen bus done");
        rst(1'b0);
        rd(`TECD_REG_STATUS, 32'h0, 2'h0);
        look(8'h00);
        $display("test second reset done");
        give_verdict;
    end
endmodule

/* tecd_decoder.v */
/*
 * terminal escape command decoder: parses host bytes written over
 * axi4-lite and keeps menu permission, size, enlargement and attributes.
 * assumes the serial receiver hands bytes in by writes to rxdata and
 * that the renderer samples the setting outputs with each character.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tecd_map.vh"

// How it works
// R1: menu permission command is escape, 0x57, then one parameter byte.
// R2: parameter 0x30 permits the menu, 0x31 inhibits it.
// R3: menu output shows only while permitted; renderer then offers modes.
// R4: at reset permission is taken from the configuration switch.
// R5: escape then 0x26 requests erasure of all text and graphics.
// R6: after a clear, updates redraw only updated parts: partial flag.
// R7: size command 0x29: 0x30 normal 16x8, 0x31 half 8x8.
// R8: size persists until screen switch or new command; default normal.
// R9: enlargement 0x2a with 0x30..0x35 selects none to 4x4.
// R10: enlargement applies to both character sizes alike.
// R11: enlargement persists until screen switch or new command; none default.
// R12: escape 0x21 clears inverse and flashing.
// R13: escape 0x22 sets inverse, others unchanged.
// R14: escape 0x23 clears inverse only.
// R15: escape 0x24 sets flashing, others unchanged.
// R16: escape 0x25 clears flashing only.
// R17: inverse holds until end-inverse or normal command.
// R18: inverse and flashing together give flashing inverse.
// R19: attributes normal on each new screen, otherwise persist.
// R20: out-of-range parameter bytes are ignored, setting unchanged.
module tecd_decoder
(
    input  wire        mclk,
    input  wire        nrst,
    input  wire        menu_permission_config_switch,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         menu_show,
    output reg         clear_req,
    output reg         partial_redraw,
    output reg         char_half,
    output reg  [2:0]  enlarge_sel,
    output reg         attr_inverse,
    output reg         attr_flash,
    output reg         attr_flash_inverse
);

// ----------------------------------------------------------------------
// parser states
// ----------------------------------------------------------------------
localparam [1:0] ST_IDLE  = 2'h0;
localparam [1:0] ST_ESC   = 2'h1;
localparam [1:0] ST_PARAM = 2'h2;

reg  [1:0]  state_q;
reg  [7:0]  cmd_q;
reg  [3:0]  awaddr_q;
reg  [31:0] wdata_q;
reg  [3:0]  wstrb_q;
reg         aw_have_q;
reg         w_have_q;
reg         sw_sync1_q;
reg         sw_sync2_q;
reg         boot_q;
reg         clr_pend_q;

wire        wr_fire;
wire        byte_vld;
wire [7:0]  rx_byte;
wire        screen_new;
wire        clr_done;
wire        ar_fire;

// lane 0 must be enabled for a byte or control bit to take effect
function wr_hit;
    input [3:0] addr;
    input [3:0] target;
    input [3:0] strb;
    begin
        wr_hit = (addr == target) && strb[0];
    end
endfunction

// only the two write-only registers accept a write
function wr_legal;
    input [3:0] addr;
    begin
        wr_legal = (addr == `TECD_REG_RXDATA) || (addr == `TECD_REG_CTRL);
    end
endfunction

// ----------------------------------------------------------------------
// axi4-lite write channel
// ----------------------------------------------------------------------
// one write at a time: nothing is taken while the response waits
assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

always @(posedge mclk)
begin
    if (!nrst)
    begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        awaddr_q     <= 4'h0;
        wdata_q      <= 32'h0000_0000;
        wstrb_q      <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `TECD_RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_legal(awaddr_q))
                s_axi_bresp <= `TECD_RESP_OKAY;
            else
                s_axi_bresp <= `TECD_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// write decode: byte and control strobes
// ----------------------------------------------------------------------
assign byte_vld = wr_fire && wr_hit(awaddr_q, `TECD_REG_RXDATA, wstrb_q);
assign rx_byte  = wdata_q[7:0];
assign screen_new = wr_fire && wr_hit(awaddr_q, `TECD_REG_CTRL, wstrb_q)
                    && wdata_q[`TECD_CTRL_SCREEN_NEW];
assign clr_done   = wr_fire && wr_hit(awaddr_q, `TECD_REG_CTRL, wstrb_q)
                    && wdata_q[`TECD_CTRL_CLR_DONE];

// ----------------------------------------------------------------------
// configuration switch synchroniser
// ----------------------------------------------------------------------
// no reset here: the pair keeps sampling the strap through reset, so
// the settled switch level is ready at the first edge after release
always @(posedge mclk)
begin
    sw_sync1_q <= menu_permission_config_switch;
    sw_sync2_q <= sw_sync1_q;                                 // [R4]
end

// ----------------------------------------------------------------------
// escape parser and stored settings
// ----------------------------------------------------------------------
always @(posedge mclk)
begin
    if (!nrst)
    begin
        state_q        <= ST_IDLE;
        cmd_q          <= 8'h00;
        boot_q         <= 1'b1;
        menu_show      <= 1'b0;
        clear_req      <= 1'b0;
        clr_pend_q     <= 1'b0;
        partial_redraw <= 1'b0;
        char_half      <= 1'b0;                               // [R8]
        enlarge_sel    <= `TECD_ENL_NONE;                     // [R11]
        attr_inverse   <= 1'b0;
        attr_flash     <= 1'b0;
        attr_flash_inverse <= 1'b0;
    end
    else
    begin
        clear_req <= 1'b0;
        // switch setting loaded once synchroniser has settled
        if (boot_q)
        begin
            boot_q    <= 1'b0;
            menu_show <= sw_sync2_q;                          // [R4]
        end
        if (clr_done)
            clr_pend_q <= 1'b0;
        if (screen_new)
        begin
            char_half      <= 1'b0;                           // [R8]
            enlarge_sel    <= `TECD_ENL_NONE;                 // [R11]
            attr_inverse   <= 1'b0;                           // [R19]
            attr_flash     <= 1'b0;                           // [R19]
            attr_flash_inverse <= 1'b0;                       // [R19]
            partial_redraw <= 1'b0;
        end
        else if (byte_vld)
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (rx_byte == `TECD_ESC)
                        state_q <= ST_ESC;
                end
                ST_ESC:
                begin
                    state_q <= ST_IDLE;
                    cmd_q   <= rx_byte;
                    case (rx_byte)
                        `TECD_CMD_MENU,
                        `TECD_CMD_SIZE,
                        `TECD_CMD_ENLARGE:
                            state_q <= ST_PARAM;              // [R1]
                        `TECD_CMD_CLEAR:
                        begin
                            clear_req      <= 1'b1;           // [R5]
                            clr_pend_q     <= 1'b1;
                            partial_redraw <= 1'b1;           // [R6]
                        end
                        `TECD_CMD_NORMAL:
                        begin
                            attr_inverse <= 1'b0;             // [R12] [R17]
                            attr_flash   <= 1'b0;             // [R12]
                            attr_flash_inverse <= 1'b0;       // [R12]
                        end
                        `TECD_CMD_INV_ON:
                        begin
                            attr_inverse       <= 1'b1;       // [R13]
                            attr_flash_inverse <= attr_flash; // [R18]
                        end
                        `TECD_CMD_INV_OFF:
                        begin
                            attr_inverse       <= 1'b0;       // [R14] [R17]
                            attr_flash_inverse <= 1'b0;       // [R18]
                        end
                        `TECD_CMD_FLASH_ON:
                        begin
                            attr_flash         <= 1'b1;       // [R15]
                            attr_flash_inverse <= attr_inverse; // [R18]
                        end
                        `TECD_CMD_FLASH_OFF:
                        begin
                            attr_flash         <= 1'b0;       // [R16]
                            attr_flash_inverse <= 1'b0;       // [R18]
                        end
                        `TECD_ESC:
                            state_q <= ST_ESC;
                        default:
                            state_q <= ST_IDLE;
                    endcase
                end
                ST_PARAM:
                begin
                    state_q <= ST_IDLE;
                    case (cmd_q)
                        `TECD_CMD_MENU:
                        begin
                            if (rx_byte == `TECD_PARAM_0)
                                menu_show <= 1'b1;            // [R2] [R3]
                            else if (rx_byte == `TECD_PARAM_1)
                                menu_show <= 1'b0;            // [R2] [R3]
                        end
                        `TECD_CMD_SIZE:
                        begin
                            if (rx_byte == `TECD_PARAM_0)
                                char_half <= 1'b0;            // [R7]
                            else if (rx_byte == `TECD_PARAM_1)
                                char_half <= 1'b1;            // [R7]
                        end
                        `TECD_CMD_ENLARGE:
                        begin
                            // size and enlargement stay independent
                            if ((rx_byte >= `TECD_PARAM_0)
                                && (rx_byte <= `TECD_PARAM_MAX))
                                enlarge_sel <= rx_byte[2:0];  // [R9] [R10]
                        end
                        default:
                            state_q <= ST_IDLE;
                    endcase                                   // [R20]
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
end

// ----------------------------------------------------------------------
// axi4-lite read channel
// ----------------------------------------------------------------------
// read data is captured at the address handshake and held until taken
assign s_axi_arready = !s_axi_rvalid;
assign ar_fire       = s_axi_arvalid && s_axi_arready;

always @(posedge mclk)
begin
    if (!nrst)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= `TECD_RESP_OKAY;
    end
    else if (ar_fire)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `TECD_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
            `TECD_REG_STATUS:
            begin
                s_axi_rdata[`TECD_ST_MENU]   <= menu_show;
                s_axi_rdata[`TECD_ST_SIZE]   <= char_half;
                s_axi_rdata[`TECD_ST_INV]    <= attr_inverse;
                s_axi_rdata[`TECD_ST_FLASH]  <= attr_flash;
                s_axi_rdata[`TECD_ST_ENL_LSB+2:`TECD_ST_ENL_LSB]
                                             <= enlarge_sel;
                s_axi_rdata[`TECD_ST_CLR_PEND]   <= clr_pend_q;
                s_axi_rdata[`TECD_ST_PARAM_WAIT] <= (state_q != ST_IDLE);
            end
            `TECD_REG_SCREEN:
                s_axi_rdata[0] <= partial_redraw;
            `TECD_REG_CTRL,
            `TECD_REG_RXDATA:
                s_axi_rdata <= 32'h0000_0000;
            default:
                s_axi_rresp <= `TECD_RESP_SLVERR;
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

endmodule

/* tecd_decoder_assertions.sv */
/* port-level checker for the escape command decoder.
   assumes one clock mclk and a synchronous active-low reset nrst. */
`timescale 1ns/1ns
module tecd_chk
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        menu_show,
    input wire logic        clear_req,
    input wire logic        partial_redraw,
    input wire logic        char_half,
    input wire logic [2:0]  enlarge_sel,
    input wire logic        attr_inverse,
    input wire logic        attr_flash,
    input wire logic        attr_flash_inverse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_clr_pulse: assert property (
        clear_req |=> !clear_req) else $error("clear pulse too long");
    a_clr_cause: assert property (
        clear_req |-> $rose(s_axi_bvalid)) else $error("stray clear");
    a_partial_set: assert property (
        clear_req |-> ##[0:1] partial_redraw) else $error("no partial");
    a_flash_inv: assert property (
        attr_flash_inverse == (attr_inverse && attr_flash))
        else $error("flash inverse wrong");
    a_enl_range: assert property (
        enlarge_sel <= 3'h5) else $error("enlarge out of range");
    a_set_cause: assert property (
        !$stable({char_half, enlarge_sel, attr_inverse, attr_flash})
        |-> $rose(s_axi_bvalid)) else $error("setting moved alone");
    a_menu_cause: assert property (
        $past(nrst) && $past(nrst, 2) && !$stable(menu_show)
        |-> $rose(s_axi_bvalid)) else $error("menu moved alone");
    a_b_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_r_block: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read during response");
endmodule

bind tecd_decoder tecd_chk chk_u (.*);

/* tecd_host_model.sv */
/* host model: axi4-lite master that hands bytes to the decoder.
   assumes the bench calls axi_wr and axi_rd one at a time. */
`timescale 1ns/1ns
module tecd_host_model
(
    input  wire logic        mclk,
    output logic [3:0]  s_axi_awaddr = 4'h0,
    output logic        s_axi_awvalid = 1'b0,
    input  wire logic        s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0]  s_axi_wstrb = 4'hf,
    output logic        s_axi_wvalid = 1'b0,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic        s_axi_bready = 1'b0,
    output logic [3:0]  s_axi_araddr = 4'h0,
    output logic        s_axi_arvalid = 1'b0,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic        s_axi_rready = 1'b0
);
    // released lines go to the inverse so stale values never look valid
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
        logic a_ok, w_ok, b_ok;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge mclk);
            a_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge mclk);
            if (a_ok) s_axi_awvalid <= 1'b0;
            if (a_ok) s_axi_awaddr <= ~a;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (w_ok) s_axi_wdata <= ~d;
        end
        while (!b_ok);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        logic a_ok, r_ok;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge mclk);
            a_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge mclk);
            if (a_ok) s_axi_arvalid <= 1'b0;
            if (a_ok) s_axi_araddr <= ~a;
        end
        while (!r_ok);
        s_axi_rready <= 1'b0;
    endtask
endmodule

/* tecd_map.vh */
/*
 * constants of the terminal escape command decoder: command bytes,
 * parameter codes and the register map of its software slave.
 * assumes inclusion by bare name from the design file.
 */
`ifndef TECD_MAP_VH
`define TECD_MAP_VH

// ----------------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------------
`define TECD_ESC            8'h1b
`define TECD_CMD_MENU       8'h57
`define TECD_CMD_CLEAR      8'h26
`define TECD_CMD_SIZE       8'h29
`define TECD_CMD_ENLARGE    8'h2a
`define TECD_CMD_NORMAL     8'h21
`define TECD_CMD_INV_ON     8'h22
`define TECD_CMD_INV_OFF    8'h23
`define TECD_CMD_FLASH_ON   8'h24
`define TECD_CMD_FLASH_OFF  8'h25

// ----------------------------------------------------------------------
// parameter bytes
// ----------------------------------------------------------------------
`define TECD_PARAM_0        8'h30
`define TECD_PARAM_1        8'h31
`define TECD_PARAM_MAX      8'h35

// ----------------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------------
`define TECD_REG_CTRL       4'h0
`define TECD_REG_RXDATA     4'h4
`define TECD_REG_STATUS     4'h8
`define TECD_REG_SCREEN     4'hc

// ctrl fields
`define TECD_CTRL_SCREEN_NEW  0
`define TECD_CTRL_CLR_DONE    1

// status fields
`define TECD_ST_MENU        0
`define TECD_ST_SIZE        1
`define TECD_ST_INV         2
`define TECD_ST_FLASH       3
`define TECD_ST_ENL_LSB     4
`define TECD_ST_CLR_PEND    8
`define TECD_ST_PARAM_WAIT  9

// reset values and the error response
`define TECD_ENL_NONE       3'h0
`define TECD_RESP_OKAY      2'h0
`define TECD_RESP_SLVERR    2'h2

`endif
